/* app_side_model.sv */
`timescale 1ns/100ps

// application side: time base and peer delay loader
module app_side_model #(
    parameter int TOGGLE_CYCLES = 20
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         nrst,
    // commands from the bench
    input  wire logic         toggle_en,
    input  wire logic [3:0]   load_req,
    input  wire logic [29:0]  load_val,
    // sideband towards the block
    output logic      [3:0]   millisecond_toggle,
    output logic      [119:0] peer_delay,
    output logic      [3:0]   peer_delay_valid
);
    int count;

    // short period stands in for 1 ms so a lost time base is reached quickly
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            count              <= 0;
            millisecond_toggle <= 4'h0;
        end
        else if (toggle_en)
        begin
            count <= (count == TOGGLE_CYCLES - 1) ? 0 : count + 1;
            if (count == TOGGLE_CYCLES - 1)
                millisecond_toggle <= ~millisecond_toggle;
        end
    end

    // after the strobe the slice carries junk, so a late capture shows
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            peer_delay       <= 120'h0;
            peer_delay_valid <= 4'h0;
        end
        else
        begin
            peer_delay_valid <= load_req;
            for (int c = 0; c < 4; c++)
                if (load_req[c])
                    peer_delay[c*30 +: 30] <= load_val;
                else if (peer_delay_valid[c])
                    peer_delay[c*30 +: 30] <= ~peer_delay[c*30 +: 30];
        end
    end
endmodule

/* mac_sideband_pkg.sv */
package mac_sideband_pkg;

    // ------------------------------------------------------------------
    // quad geometry
    // ------------------------------------------------------------------
    localparam int CHANNELS        = 4;
    localparam int CLASSES         = 8;
    localparam int PEER_DELAY_W    = 30;
    localparam int CORR_W          = 64;
    localparam int QUANTA_W        = 16;
    localparam int COUNTERS        = 2 * CHANNELS * CLASSES;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam longint unsigned CLK_FREQ_HZ   = 64'd20_000_000;
    localparam longint unsigned TB_PERIOD_US  = 64'd1000;
    localparam longint unsigned TB_CYCLES_L   = (TB_PERIOD_US * CLK_FREQ_HZ + 64'd999_999) / 64'd1_000_000;
    localparam int              TB_CYCLES     = int'(TB_CYCLES_L);
    // two missed toggles before the time base is declared lost
    localparam int              TB_TIMEOUT    = 2 * TB_CYCLES;
    localparam int              QUANTA_CYCLES = 8;

    // ------------------------------------------------------------------
    // register map (byte offsets, 32-bit words)
    // ------------------------------------------------------------------
    localparam logic [3:0] OFS_CTRL       = 4'h0;
    localparam logic [3:0] OFS_STATUS     = 4'h4;
    localparam logic [3:0] OFS_IRQ_STATUS = 4'h8;
    localparam logic [3:0] OFS_IRQ_MASK   = 4'hc;

    // control fields
    localparam int         CTRL_PFC_MODE_BIT  = 0;
    localparam int         CTRL_COMPAT_BIT    = 1;
    localparam int         CTRL_HOLD_REQ_BIT  = 2;
    localparam logic [2:0] CTRL_RESET         = 3'h0;

    // status and interrupt field positions (4 bits each)
    localparam int         STAT_STOPPED_POS   = 0;
    localparam int         STAT_LPI_POS       = 4;
    localparam int         STAT_TB_ALIVE_POS  = 8;
    localparam int         IRQ_PD_LOAD_POS    = 0;
    localparam int         IRQ_TB_LOST_POS    = 4;
    localparam int         IRQ_PAUSE_POS      = 8;
    localparam logic [11:0] IRQ_MASK_RESET    = 12'h000;

endpackage

/* mac_tx_sideband.sv */
`timescale 1ns/100ps

// Behaviour
// RULE1: per channel, while the hold request is high the preemptable path is held, preempting its frame if needed.
// RULE2: with the hold request unused, the preemptable path is held whenever the express FIFO is non-empty.
// RULE3: while the synchronised low-power hold is high no new frame starts on that channel.
// RULE4: the application inverts each channel's millisecond toggle once every 1 ms as a time base.
// RULE5: a high transmit halt stops the channel only after the frame in progress is complete.
// RULE6: while halt stays high no further frame starts, and starts resume once it is low again.
// RULE7: in PFC mode the synchronised 8-bit generation vectors request PFC frames per class, per express and preemptable MAC.
// RULE8: in link pause mode only bit 0 of each channel's generation byte is used and the rest ignored.
// RULE9: a 30-bit peer delay per channel is kept and added to the correction field of every one-step update.
// RULE10: the application pulses the peer delay strobe for one cycle after updating the value so it is written in.
// RULE11: once the strobe is low again the peer delay bus is ignored and may carry anything.
// RULE12: when peer delay is unused the application ties value and strobe to zero.
// RULE13: each pause-active bit is high while its class counter runs, started by a received Xoff frame.
// RULE14: in link pause mode link pause shows on bit 0 of each channel's pause-active byte.
// RULE15: in link pause mode with the compatibility bit clear the transmitter stops while the pause counter runs.
// RULE16: with the compatibility bit set transmission continues and the application enforces flow control by halt.
// RULE17: every channel's inputs and outputs act on that channel alone.
module mac_tx_sideband #(
    parameter int TB_TIMEOUT_CYCLES = mac_sideband_pkg::TB_TIMEOUT,
    parameter int QUANTA_CYCLES     = mac_sideband_pkg::QUANTA_CYCLES
) (
    // clock and reset
    input  wire logic          CLK,
    input  wire logic          NRST,
    // register port
    input  wire logic [3:0]    ADDR,
    input  wire logic [31:0]   WDATA,
    input  wire logic          WR,
    input  wire logic          RD,
    output logic      [31:0]   RDATA,
    output logic               IRQ,
    // application sideband, per channel
    input  wire logic [3:0]    TX_HOLD_REQ,
    input  wire logic [3:0]    LPI_TXHOLD,
    input  wire logic [3:0]    MILLISECOND_TOGGLE,
    input  wire logic [3:0]    MAC_STOP_TX,
    input  wire logic [31:0]   EXPRESS_XOFF_GEN,
    input  wire logic [31:0]   PREEMPT_XOFF_GEN,
    input  wire logic [119:0]  PEER_DELAY,
    input  wire logic [3:0]    PEER_DELAY_VALID,
    output logic      [31:0]   EXPRESS_PAUSE_ON,
    output logic      [31:0]   PREEMPT_PAUSE_ON,
    // transmit engine status
    input  wire logic [3:0]    EXPRESS_FIFO_NONEMPTY,
    input  wire logic [3:0]    EXPRESS_FRAME_ACTIVE,
    input  wire logic [3:0]    PREEMPT_FRAME_ACTIVE,
    // transmit engine control
    output logic      [3:0]    EXPRESS_START_OK,
    output logic      [3:0]    PREEMPT_START_OK,
    output logic      [3:0]    PREEMPT_HOLD,
    output logic      [3:0]    TX_STOPPED,
    output logic      [31:0]   EXPRESS_XOFF_REQ,
    output logic      [31:0]   PREEMPT_XOFF_REQ,
    // received pause frames
    input  wire logic          RX_PAUSE_VALID,
    input  wire logic          RX_PAUSE_PREEMPT,
    input  wire logic [1:0]    RX_PAUSE_CHAN,
    input  wire logic [7:0]    RX_PAUSE_CLASS_EN,
    input  wire logic [15:0]   RX_PAUSE_QUANTA,
    // one-step correction update
    input  wire logic          CORR_REQ,
    input  wire logic [1:0]    CORR_CHAN,
    input  wire logic [63:0]   CORR_IN,
    output logic      [63:0]   CORR_OUT,
    output logic               CORR_VALID
);
    localparam int TBW = $clog2(TB_TIMEOUT_CYCLES + 1);
    localparam int QW  = $clog2(QUANTA_CYCLES + 1);

    initial
    begin
        if (TB_TIMEOUT_CYCLES < 2)
            $error("mac_tx_sideband: TB_TIMEOUT_CYCLES must be at least 2");
        if (QUANTA_CYCLES < 1)
            $error("mac_tx_sideband: QUANTA_CYCLES must be at least 1");
    end

    // ------------------------------------------------------------------
    // synchronisers for the asynchronous inputs
    // ------------------------------------------------------------------
    logic [71:0] sync_q;
    logic [3:0]  lpi_s;
    logic [3:0]  tgl_s;
    logic [31:0] exp_gen_s;
    logic [31:0] pre_gen_s;

    sideband_sync #(.WIDTH(72)) u_sync (
        .clk  (CLK),
        .nrst (NRST),
        .d    ({PREEMPT_XOFF_GEN, EXPRESS_XOFF_GEN, MILLISECOND_TOGGLE, LPI_TXHOLD}),
        .q    (sync_q)
    );

    assign lpi_s     = sync_q[3:0];
    assign tgl_s     = sync_q[7:4];
    assign exp_gen_s = sync_q[39:8];
    assign pre_gen_s = sync_q[71:40];

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [2:0]  ctrl;
    logic [11:0] irq_status;
    logic [11:0] irq_mask;
    logic [11:0] irq_event;
    logic [11:0] status_word;
    logic        pfc_mode;
    logic        compat;
    logic        hold_req_used;

    assign pfc_mode      = ctrl[mac_sideband_pkg::CTRL_PFC_MODE_BIT];
    assign compat        = ctrl[mac_sideband_pkg::CTRL_COMPAT_BIT];
    assign hold_req_used = ctrl[mac_sideband_pkg::CTRL_HOLD_REQ_BIT];

    wire         wr_ctrl  = WR && (ADDR == mac_sideband_pkg::OFS_CTRL);
    wire         wr_irqs  = WR && (ADDR == mac_sideband_pkg::OFS_IRQ_STATUS);
    wire         wr_mask  = WR && (ADDR == mac_sideband_pkg::OFS_IRQ_MASK);
    wire  [11:0] irq_clr  = wr_irqs ? WDATA[11:0] : 12'h000;
    // a new event in the clearing cycle survives the write-one-to-clear
    wire  [11:0] next_irq = (irq_status & ~irq_clr) | irq_event;

    wire  [31:0] rd_mux =
        (ADDR == mac_sideband_pkg::OFS_CTRL)       ? {29'h0000000, ctrl} :
        (ADDR == mac_sideband_pkg::OFS_STATUS)     ? {20'h00000, status_word} :
        (ADDR == mac_sideband_pkg::OFS_IRQ_STATUS) ? {20'h00000, irq_status} :
        (ADDR == mac_sideband_pkg::OFS_IRQ_MASK)   ? {20'h00000, irq_mask} :
                                                     32'h00000000;

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            ctrl       <= mac_sideband_pkg::CTRL_RESET;
            irq_mask   <= mac_sideband_pkg::IRQ_MASK_RESET;
            irq_status <= 12'h000;
            RDATA      <= 32'h00000000;
            IRQ        <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl <= WDATA[2:0];
            if (wr_mask)
                irq_mask <= WDATA[11:0];
            irq_status <= next_irq;
            RDATA      <= RD ? rd_mux : 32'h00000000;
            IRQ        <= |(next_irq & (wr_mask ? WDATA[11:0] : irq_mask));
        end
    end

    // ------------------------------------------------------------------
    // pause quanta time base
    // ------------------------------------------------------------------
    logic [QW-1:0] quanta_div;
    wire           quanta_tick = (quanta_div == QW'(QUANTA_CYCLES - 1));

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            quanta_div <= '0;
        else
            quanta_div <= quanta_tick ? '0 : quanta_div + QW'(1);
    end

    // ------------------------------------------------------------------
    // received pause counters: index = mac*32 + channel*8 + class
    // ------------------------------------------------------------------
    logic [15:0] pause_cnt [mac_sideband_pkg::COUNTERS];
    logic [63:0] pause_on;
    logic [63:0] pause_rise;

    for (genvar i = 0; i < mac_sideband_pkg::COUNTERS; i++)
    begin : g_pause
        localparam int  M   = i / 32;
        localparam int  C   = (i / 8) % 4;
        localparam int  K   = i % 8;
        localparam logic       M_B = M[0];
        localparam logic [1:0] C_B = C[1:0];
        // link pause carries only class 0
        wire        hit = RX_PAUSE_VALID && (RX_PAUSE_PREEMPT == M_B) && (RX_PAUSE_CHAN == C_B)
                          && RX_PAUSE_CLASS_EN[K] && (pfc_mode || (K == 0)); // [RULE14]
        wire [15:0] next_cnt = hit ? RX_PAUSE_QUANTA :
                               (quanta_tick && (pause_cnt[i] != 16'h0000)) ? pause_cnt[i] - 16'h0001 :
                               pause_cnt[i];

        assign pause_rise[i] = (next_cnt != 16'h0000) && !pause_on[i];

        always_ff @(posedge CLK or negedge NRST)
        begin
            if (!NRST)
            begin
                pause_cnt[i] <= 16'h0000;
                pause_on[i]  <= 1'b0;
            end
            else
            begin
                pause_cnt[i] <= next_cnt;
                pause_on[i]  <= (next_cnt != 16'h0000); // [RULE13]
            end
        end
    end

    assign EXPRESS_PAUSE_ON = pause_on[31:0];
    assign PREEMPT_PAUSE_ON = pause_on[63:32];

    // ------------------------------------------------------------------
    // per-channel transmit control
    // ------------------------------------------------------------------
    logic [29:0] peer_delay [mac_sideband_pkg::CHANNELS];
    logic [3:0]  tgl_prev;
    logic [3:0]  tb_alive;
    logic [TBW-1:0] tb_cnt [mac_sideband_pkg::CHANNELS];

    for (genvar c = 0; c < mac_sideband_pkg::CHANNELS; c++)
    begin : g_chan
        // hold request overrides the automatic express-FIFO trigger only when enabled
        wire pre_hold   = hold_req_used ? TX_HOLD_REQ[c] : EXPRESS_FIFO_NONEMPTY[c]; // [RULE1] [RULE2]
        // with compatibility set the received pause never gates the transmitter
        wire link_pause_e = !pfc_mode && !compat && pause_on[c*8];        // [RULE15] [RULE16]
        wire link_pause_p = !pfc_mode && !compat && pause_on[32 + c*8];   // [RULE15] [RULE16]
        // start permission only gates new frames, so a frame already going finishes
        wire block      = MAC_STOP_TX[c] || lpi_s[c];                     // [RULE3] [RULE5] [RULE6]
        wire tb_edge    = tgl_s[c] ^ tgl_prev[c];
        wire tb_expire  = (tb_cnt[c] == TBW'(TB_TIMEOUT_CYCLES - 1));
        wire tb_dead    = (tb_cnt[c] == TBW'(TB_TIMEOUT_CYCLES));
        wire [7:0] gen_mask = pfc_mode ? 8'hff : 8'h01;                   // [RULE8]

        assign irq_event[mac_sideband_pkg::IRQ_PD_LOAD_POS + c] = PEER_DELAY_VALID[c];
        assign irq_event[mac_sideband_pkg::IRQ_TB_LOST_POS + c] = tb_expire && !tb_edge;
        assign irq_event[mac_sideband_pkg::IRQ_PAUSE_POS + c]   =
            (|pause_rise[c*8 +: 8]) || (|pause_rise[32 + c*8 +: 8]);
        assign status_word[mac_sideband_pkg::STAT_STOPPED_POS + c]  = TX_STOPPED[c];
        assign status_word[mac_sideband_pkg::STAT_LPI_POS + c]      = lpi_s[c];
        assign status_word[mac_sideband_pkg::STAT_TB_ALIVE_POS + c] = tb_alive[c];

        always_ff @(posedge CLK or negedge NRST) // [RULE17]
        begin
            if (!NRST)
            begin
                EXPRESS_START_OK[c]       <= 1'b0;
                PREEMPT_START_OK[c]       <= 1'b0;
                PREEMPT_HOLD[c]           <= 1'b0;
                TX_STOPPED[c]             <= 1'b0;
                EXPRESS_XOFF_REQ[c*8 +: 8] <= 8'h00;
                PREEMPT_XOFF_REQ[c*8 +: 8] <= 8'h00;
                peer_delay[c]             <= 30'h00000000;
                tgl_prev[c]               <= 1'b0;
                tb_cnt[c]                 <= '0;
                tb_alive[c]               <= 1'b0;
            end
            else
            begin
                EXPRESS_START_OK[c] <= !block && !link_pause_e;
                PREEMPT_START_OK[c] <= !block && !link_pause_p && !pre_hold;
                PREEMPT_HOLD[c]     <= pre_hold;                                  // [RULE1]
                TX_STOPPED[c]       <= MAC_STOP_TX[c] && !EXPRESS_FRAME_ACTIVE[c]
                                       && !PREEMPT_FRAME_ACTIVE[c];               // [RULE5]
                EXPRESS_XOFF_REQ[c*8 +: 8] <= exp_gen_s[c*8 +: 8] & gen_mask;     // [RULE7]
                PREEMPT_XOFF_REQ[c*8 +: 8] <= pre_gen_s[c*8 +: 8] & gen_mask;     // [RULE7]
                // the bus is sampled only on the strobe and ignored otherwise
                if (PEER_DELAY_VALID[c])
                    peer_delay[c] <= PEER_DELAY[c*30 +: 30];                      // [RULE11]
                tgl_prev[c] <= tgl_s[c];
                // watchdog: the counter parks one past expiry, so a missing toggle is reported once
                if (tb_edge)
                begin
                    tb_cnt[c]   <= '0;
                    tb_alive[c] <= 1'b1;
                end
                else if (!tb_dead)
                begin
                    tb_cnt[c] <= tb_cnt[c] + TBW'(1);
                    if (tb_expire)
                        tb_alive[c] <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // one-step correction: add the stored peer delay of the chosen channel
    // ------------------------------------------------------------------
    wire [63:0] corr_sum = CORR_IN + {34'h000000000, peer_delay[CORR_CHAN]}; // [RULE9]

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            CORR_OUT   <= 64'h0000000000000000;
            CORR_VALID <= 1'b0;
        end
        else
        begin
            CORR_VALID <= CORR_REQ;
            if (CORR_REQ)
                CORR_OUT <= corr_sum;
        end
    end
endmodule

/* mac_tx_sideband_chk.sv */
`timescale 1ns/100ps

module mac_tx_sideband_chk (
    // clock and reset
    input wire logic        CLK,
    input wire logic        NRST,
    // observed ports
    input wire logic        RD,
    input wire logic [31:0] RDATA,
    input wire logic [3:0]  MAC_STOP_TX,
    input wire logic [3:0]  LPI_TXHOLD,
    input wire logic [3:0]  EXPRESS_FRAME_ACTIVE,
    input wire logic [3:0]  PREEMPT_FRAME_ACTIVE,
    input wire logic [3:0]  EXPRESS_START_OK,
    input wire logic [3:0]  PREEMPT_START_OK,
    input wire logic [3:0]  PREEMPT_HOLD,
    input wire logic [3:0]  TX_STOPPED,
    input wire logic        RX_PAUSE_VALID,
    input wire logic        RX_PAUSE_PREEMPT,
    input wire logic [1:0]  RX_PAUSE_CHAN,
    input wire logic [7:0]  RX_PAUSE_CLASS_EN,
    input wire logic [15:0] RX_PAUSE_QUANTA,
    input wire logic [31:0] EXPRESS_PAUSE_ON,
    input wire logic [31:0] PREEMPT_PAUSE_ON,
    input wire logic        CORR_REQ,
    input wire logic        CORR_VALID
);
    wire logic [63:0] pause_all;
    wire logic        rx_on;
    assign pause_all = {PREEMPT_PAUSE_ON, EXPRESS_PAUSE_ON};
    assign rx_on     = RX_PAUSE_VALID && RX_PAUSE_CLASS_EN[0];

    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    a_rdata_idle: assert property (!$past(RD) |-> RDATA == 32'h0)
        else $error("read data not zero outside the answer cycle");
    a_stop_blocks_start: assert property (1'b1 |=> ((EXPRESS_START_OK | PREEMPT_START_OK) & $past(MAC_STOP_TX)) == 4'h0)
        else $error("start allowed while halt high");
    a_stopped_cause: assert property (1'b1 |=> TX_STOPPED == ($past(MAC_STOP_TX) & ~$past(EXPRESS_FRAME_ACTIVE) & ~$past(PREEMPT_FRAME_ACTIVE)))
        else $error("stopped flag disagrees with halt and frame state");
    a_hold_no_start: assert property ((PREEMPT_START_OK & PREEMPT_HOLD) == 4'h0)
        else $error("preemptable start allowed while held");
    // synchroniser needs at most five edges, so six stable cycles must show
    a_lpi_blocks: assert property ($stable(LPI_TXHOLD) [*6] |=> (EXPRESS_START_OK & LPI_TXHOLD) == 4'h0)
        else $error("start allowed under low-power hold");
    a_pause_start: assert property (rx_on && RX_PAUSE_QUANTA != 16'h0 |=> pause_all[{$past(RX_PAUSE_PREEMPT), $past(RX_PAUSE_CHAN), 3'h0}])
        else $error("pause active not raised after pause frame");
    a_pause_xon: assert property (rx_on && RX_PAUSE_QUANTA == 16'h0 |=> !pause_all[{$past(RX_PAUSE_PREEMPT), $past(RX_PAUSE_CHAN), 3'h0}])
        else $error("pause active still high after zero quanta");
    a_corr_latency: assert property (CORR_REQ |=> CORR_VALID)
        else $error("correction result missing");
    a_corr_pulse: assert property (CORR_VALID |-> $past(CORR_REQ))
        else $error("correction valid without request");

    cover property (rx_on && RX_PAUSE_QUANTA != 16'h0);
    cover property ((MAC_STOP_TX & EXPRESS_FRAME_ACTIVE) != 4'h0);
    cover property (CORR_REQ);
endmodule

bind mac_tx_sideband mac_tx_sideband_chk i_mac_tx_sideband_chk (.*);

/* sideband_sync.sv */
`timescale 1ns/100ps

// three-stage synchroniser; a change is taken once stages two and three agree
module sideband_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    // signals
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    initial
    begin
        if (WIDTH < 1)
            $error("sideband_sync: WIDTH must be at least 1");
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            q      <= '0;
        end
        else
        begin
            stage1 <= d;
            stage2 <= stage1;
            stage3 <= stage2;
            // per bit: stage two and three must match before the output follows
            q      <= (q & (stage2 ^ stage3)) | (stage2 & ~(stage2 ^ stage3));
        end
    end
endmodule

/* testbench.sv */
`timescale 1ns/100ps

module testbench;
    logic        CLK = 1'b0, NRST = 1'b0, WR = 1'b0, RD = 1'b0, IRQ, CORR_REQ = 1'b0, CORR_VALID;
    logic        RX_PAUSE_VALID = 1'b0, RX_PAUSE_PREEMPT = 1'b0, toggle_en = 1'b1;
    logic [1:0]  RX_PAUSE_CHAN = 2'h0, CORR_CHAN = 2'h0;
    logic [3:0]  ADDR = 4'h0, TX_HOLD_REQ = 4'h0, LPI_TXHOLD = 4'h0, MAC_STOP_TX = 4'h0, load_req = 4'h0;
    logic [3:0]  EXPRESS_FIFO_NONEMPTY = 4'h0, EXPRESS_FRAME_ACTIVE = 4'h0, PREEMPT_FRAME_ACTIVE = 4'h0;
    logic [3:0]  MILLISECOND_TOGGLE, PEER_DELAY_VALID, EXPRESS_START_OK, PREEMPT_START_OK, PREEMPT_HOLD, TX_STOPPED;
    logic [7:0]  RX_PAUSE_CLASS_EN = 8'h0;
    logic [15:0] RX_PAUSE_QUANTA = 16'h0;
    logic [29:0] load_val = 30'h0, v;
    logic [31:0] WDATA = 32'h0, EXPRESS_XOFF_GEN = 32'h0, PREEMPT_XOFF_GEN = 32'h0, r;
    logic [31:0] RDATA, EXPRESS_PAUSE_ON, PREEMPT_PAUSE_ON, EXPRESS_XOFF_REQ, PREEMPT_XOFF_REQ;
    logic [63:0] CORR_IN = 64'h0, CORR_OUT, pd [4];
    logic [119:0] PEER_DELAY;
    int          fails = 0, checks = 0, cycles = 0, ch;

    always #25 CLK = ~CLK;

    app_side_model #(.TOGGLE_CYCLES(20)) i_app_side_model (.clk(CLK), .nrst(NRST), .toggle_en(toggle_en),
        .load_req(load_req), .load_val(load_val), .millisecond_toggle(MILLISECOND_TOGGLE),
        .peer_delay(PEER_DELAY), .peer_delay_valid(PEER_DELAY_VALID));

    // every port of i_mac_tx_sideband meets a bench signal of the same name
    mac_tx_sideband #(.TB_TIMEOUT_CYCLES(50), .QUANTA_CYCLES(2)) i_mac_tx_sideband (.*);

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("comparisons %0d, mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1;
        d = RDATA;
    endtask

    task automatic rx(input int c, input logic p, input logic [7:0] en, input logic [15:0] q);
        @(posedge CLK);
        RX_PAUSE_VALID <= 1'b1;
        RX_PAUSE_PREEMPT <= p;
        RX_PAUSE_CHAN <= 2'(c);
        RX_PAUSE_CLASS_EN <= en;
        RX_PAUSE_QUANTA <= q;
        @(posedge CLK);
        RX_PAUSE_VALID <= 1'b0;
        #1;
    endtask

    task automatic corr(input int c, input logic [63:0] x);
        @(posedge CLK);
        CORR_REQ <= 1'b1;
        CORR_CHAN <= 2'(c);
        CORR_IN <= x;
        @(posedge CLK);
        CORR_REQ <= 1'b0;
        #1;
        chk({63'h0, CORR_VALID}, 64'h1);
        chk(CORR_OUT, x + pd[c]);
    endtask

    // hang guard: the sequence needs well under a thousand cycles
    always @(posedge CLK)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fails++;
            results();
        end
    end

    initial
    begin
        void'($urandom(41));
        repeat (16) @(posedge CLK);
        NRST <= 1'b1;
        wr(4'h0, 32'h5);
        rd(4'h0, r);
        chk(r, 32'h5);
        rd(4'h2, r);
        chk(r, 32'h0);
        for (int c = 0; c < 4; c++)
        begin
            v = 30'($urandom);
            pd[c] = 64'(v);
            @(posedge CLK);
            load_req <= 4'h1 << c;
            load_val <= v;
            @(posedge CLK);
            load_req <= 4'h0;
            settle(3);
            corr(c, {32'h0, $urandom});
        end
        corr(0, 64'h0);
        rd(4'h8, r);
        chk(r, 32'hf);
        wr(4'hc, 32'hf);
        settle(2);
        chk(IRQ, 1'b1);
        wr(4'h8, 32'hf);
        settle(2);
        chk(IRQ, 1'b0);
        @(posedge CLK);
        toggle_en <= 1'b0;
        settle(120);
        rd(4'h8, r);
        chk(r, 32'hf0);
        wr(4'hc, 32'hf0);
        settle(2);
        chk(IRQ, 1'b1);
        wr(4'h8, 32'hf0);
        settle(2);
        chk(IRQ, 1'b0);
        r = $urandom;
        @(posedge CLK);
        toggle_en <= 1'b1;
        TX_HOLD_REQ <= r[3:0];
        EXPRESS_FIFO_NONEMPTY <= ~r[3:0];
        settle(2);
        chk(PREEMPT_HOLD, r[3:0]);
        chk(PREEMPT_START_OK, 4'(~r[3:0]));
        wr(4'h0, 32'h1);
        settle(2);
        chk(PREEMPT_HOLD, 4'(~r[3:0]));
        ch = $urandom_range(3);
        @(posedge CLK);
        EXPRESS_FRAME_ACTIVE <= 4'h1 << ch;
        MAC_STOP_TX <= 4'h1 << ch;
        settle(3);
        chk(TX_STOPPED, 4'h0);
        chk(EXPRESS_START_OK, 4'(~(4'h1 << ch)));
        @(posedge CLK);
        EXPRESS_FRAME_ACTIVE <= 4'h0;
        settle(2);
        chk(TX_STOPPED, 4'h1 << ch);
        @(posedge CLK);
        MAC_STOP_TX <= 4'h0;
        LPI_TXHOLD <= 4'h1 << ch;
        settle(8);
        chk(EXPRESS_START_OK, 4'(~(4'h1 << ch)));
        rd(4'h4, r);
        chk(r & 32'hff, {24'h0, 4'(4'h1 << ch), 4'h0});
        r = $urandom;
        @(posedge CLK);
        LPI_TXHOLD <= 4'h0;
        EXPRESS_XOFF_GEN <= r;
        PREEMPT_XOFF_GEN <= ~r;
        settle(8);
        chk(EXPRESS_START_OK, 4'hf);
        chk(EXPRESS_XOFF_REQ, r);
        chk(PREEMPT_XOFF_REQ, 32'(~r));
        wr(4'h0, 32'h0);
        settle(2);
        chk(EXPRESS_XOFF_REQ, r & 32'h01010101);
        chk(PREEMPT_XOFF_REQ, 32'(~r) & 32'h01010101);
        rx(ch, 1'b0, 8'hff, 16'h4);
        chk(EXPRESS_PAUSE_ON, 32'h1 << (ch * 8));
        settle(1);
        chk(EXPRESS_START_OK, 4'(~(4'h1 << ch)));
        settle(12);
        chk(EXPRESS_PAUSE_ON, 32'h0);
        chk(EXPRESS_START_OK, 4'hf);
        wr(4'h0, 32'h2);
        rx(ch, 1'b0, 8'h1, 16'h4);
        settle(1);
        chk(EXPRESS_START_OK, 4'hf);
        wr(4'h0, 32'h1);
        r = $urandom;
        rx(ch, 1'b1, r[7:0] | 8'h1, 16'h3);
        chk(PREEMPT_PAUSE_ON, 32'(r[7:0] | 8'h1) << (ch * 8));
        rx(ch, 1'b1, 8'hff, 16'h0);
        chk(PREEMPT_PAUSE_ON, 32'h0);
        rd(4'h8, r);
        chk(r & 32'hf00, 32'h100 << ch);
        results();
    end
endmodule
